// ===== rtl/psc_cfg.svh
// Constants for the parallel to serial converter.
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH
`define PSC_BYTE_W      8
`define PSC_MSB         7
`define PSC_CNT_W       3
`define PSC_CNT_PRESET  3'h1
`define PSC_CNT_LAST    3'h0
`define PSC_FIFO_DEPTH  8
`define PSC_SHIFT_RESET 8'h00
`endif

// ===== rtl/psc_pkg.sv
// Types shared by the parallel to serial converter.
`default_nettype none
package psc_pkg;
  typedef logic [7:0] psc_byte_t;
endpackage
`default_nettype wire

// ===== rtl/psc_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`default_nettype none
module psc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } psc_fifo_st_t;
  psc_fifo_st_t    st_reg;
  psc_fifo_st_t    st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_wr;
  logic             do_rd;

  assign wr_ready_out = (st_reg.cnt != (AW+1)'(DEPTH));
  assign rd_valid_out = (st_reg.cnt != '0);
  assign rd_data_out  = mem[st_reg.rp];
  assign do_wr        = wr_valid_in && wr_ready_out;
  assign do_rd        = rd_valid_out && rd_ready_in;

  always_comb begin
    st_next = st_reg;
    if (do_wr) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (do_rd) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (do_wr) begin
      mem[st_reg.wp] <= wr_data_in;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/psc_top.sv
// Double-buffered parallel to serial converter for a disk write path.
`default_nettype none
`include "psc_cfg.svh"
module psc_top (
  input  wire logic                   core_clk_in,
  input  wire logic                   rstn_in,
  input  wire logic [`PSC_BYTE_W-1:0] parallel_in,
  input  wire logic                   byte_load_strobe_n_in,
  input  wire logic                   write_clk_in,
  input  wire logic                   output_enable_n_in,
  input  wire logic                   test_in,
  output logic                        serial_data_out,
  output logic                        serial_data_oe_n_out,
  output logic                        byte_done_flag_out,
  output logic                        byte_done_flag_oe_n_out,
  output logic                        shift_clock_copy_inv_out,
  output logic                        shift_clock_copy_inv_oe_n_out,
  output logic                        shift_clock_copy_dly_out,
  output logic                        shift_clock_copy_dly_oe_n_out,
  output logic                        counter_preset_flag_n_out,
  output logic                        load_ready_out
);
  typedef struct packed {
    logic [1:0]                 strb_sync;
    logic [1:0]                 wclk_sync;
    logic [1:0]                 en_sync;
    logic [1:0]                 test_sync;
    logic [`PSC_BYTE_W-1:0]     data_s1;
    logic [`PSC_BYTE_W-1:0]     data_s2;
    logic                       strb_d;
    logic                       wclk_d;
    logic                       wclk_d2;
    logic [`PSC_CNT_W-1:0]      cnt;
    logic                       preset_n;
    logic                       done;
    logic                       xfer;
    psc_pkg::psc_byte_t         shifter;
    psc_pkg::psc_byte_t         held;
    logic                       dout;
  } psc_st_t;

  psc_st_t            st_reg;
  psc_st_t            st_next;
  logic               strb_rise;
  logic               wclk_rise;
  logic               wclk_fall;
  logic               byte_xfer;
  logic               fifo_wr_ready;
  logic               fifo_rd_valid;
  logic               fifo_rd_ready;
  psc_pkg::psc_byte_t fifo_rd_data;

  assign strb_rise = st_reg.strb_sync[1] && !st_reg.strb_d;
  assign wclk_rise = st_reg.wclk_sync[1] && !st_reg.wclk_d;
  assign wclk_fall = !st_reg.wclk_sync[1] && st_reg.wclk_d;
  // The buffer is unloaded at every byte boundary, where the flag is set unless the load strobe is low.
  // When the FIFO is empty at a boundary, the held byte is sent again.
  assign byte_xfer = st_reg.xfer;
  assign fifo_rd_ready = byte_xfer;

  psc_fifo #(
    .WIDTH (`PSC_BYTE_W),
    .DEPTH (`PSC_FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in  (core_clk_in),
    .rstn_in      (rstn_in),
    .wr_data_in   (st_reg.data_s2),
    .wr_valid_in  (strb_rise),
    .wr_ready_out (fifo_wr_ready),
    .rd_data_out  (fifo_rd_data),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (fifo_rd_ready)
  );

  always_comb begin
    st_next           = st_reg;
    st_next.strb_sync = {st_reg.strb_sync[0], byte_load_strobe_n_in};
    st_next.wclk_sync = {st_reg.wclk_sync[0], write_clk_in};
    st_next.en_sync   = {st_reg.en_sync[0], output_enable_n_in};
    st_next.test_sync = {st_reg.test_sync[0], test_in};
    st_next.data_s1   = parallel_in;
    st_next.data_s2   = st_reg.data_s1;
    st_next.strb_d    = st_reg.strb_sync[1];
    st_next.wclk_d    = st_reg.wclk_sync[1];
    st_next.wclk_d2   = st_reg.wclk_d;
    st_next.xfer      = wclk_rise && st_reg.test_sync[1] &&
                        (st_reg.cnt == `PSC_CNT_LAST);
    if (fifo_rd_valid && fifo_rd_ready) begin
      st_next.held = fifo_rd_data;
    end
    if (wclk_rise && st_reg.test_sync[1]) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
    st_next.preset_n = st_reg.test_sync[1] ?
                       (st_next.cnt != `PSC_CNT_PRESET) : 1'b1;
    if (wclk_rise && st_reg.test_sync[1] &&
        st_reg.cnt == `PSC_CNT_LAST) begin
      st_next.done = 1'b1;
    end
    if (!st_reg.strb_sync[1]) begin
      st_next.done = 1'b0;
    end
    if (wclk_fall) begin
      st_next.dout    = st_reg.shifter[`PSC_MSB];
      st_next.shifter = {st_reg.shifter[`PSC_MSB-1:0], 1'b0};
    end
    if (byte_xfer) begin
      st_next.shifter = fifo_rd_valid ? fifo_rd_data : st_reg.held;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      st_reg           <= '0;
      st_reg.strb_sync <= 2'h3;
      st_reg.strb_d    <= 1'b1;
      st_reg.en_sync   <= 2'h3;
      st_reg.test_sync <= 2'h3;
      st_reg.preset_n  <= 1'b1;
      st_reg.shifter   <= `PSC_SHIFT_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign serial_data_out               = st_reg.dout;
  assign serial_data_oe_n_out          = st_reg.en_sync[1];
  assign byte_done_flag_out            = st_reg.done;
  assign byte_done_flag_oe_n_out       = st_reg.en_sync[1];
  assign shift_clock_copy_inv_out      = !st_reg.wclk_d;
  assign shift_clock_copy_inv_oe_n_out = st_reg.en_sync[1];
  assign shift_clock_copy_dly_out      = st_reg.wclk_d2;
  assign shift_clock_copy_dly_oe_n_out = st_reg.en_sync[1];
  assign counter_preset_flag_n_out     = st_reg.preset_n;
  assign load_ready_out                = fifo_wr_ready;
endmodule
`default_nettype wire

// ===== test/psc_props.sv
// Pin-level assertions for the converter.
`default_nettype none
module psc_props (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic byte_load_strobe_n_in,
  input wire logic write_clk_in,
  input wire logic output_enable_n_in,
  input wire logic test_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_n_out,
  input wire logic byte_done_flag_out,
  input wire logic byte_done_flag_oe_n_out,
  input wire logic shift_clock_copy_inv_out,
  input wire logic shift_clock_copy_inv_oe_n_out,
  input wire logic shift_clock_copy_dly_out,
  input wire logic shift_clock_copy_dly_oe_n_out,
  input wire logic counter_preset_flag_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic stb = byte_load_strobe_n_in;
  wire logic flg = byte_done_flag_out;
  wire logic inv = shift_clock_copy_inv_out;
  wire logic pre = counter_preset_flag_n_out;
  wire logic oe = serial_data_oe_n_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  AST_OE_SAME: assert property (
    oe == byte_done_flag_oe_n_out && oe == shift_clock_copy_inv_oe_n_out
    && oe == shift_clock_copy_dly_oe_n_out) else $error("enables differ");
  AST_OE_FOLLOW: assert property (
    $stable(output_enable_n_in)[*6] |-> oe == output_enable_n_in)
    else $error("enable not followed");
  AST_INV: assert property (
    $stable(write_clk_in)[*5] |-> inv == !write_clk_in)
    else $error("inverted copy wrong");
  AST_DLY: assert property (
    $past(rstn_in, 3) |-> shift_clock_copy_dly_out == !$past(inv))
    else $error("delayed copy wrong");
  AST_FLAG_CLR: assert property (
    !stb[*5] |-> !flg) else $error("flag not cleared by strobe");
  AST_FLAG_HOLD: assert property (
    $fell(flg) |-> !$past(stb, 2) || !$past(stb, 3) || !$past(stb, 4)
    || !$past(stb, 5)) else $error("flag dropped without load");
  AST_DATA_EDGE: assert property (
    $changed(serial_data_out) |-> ##[0:2] inv)
    else $error("data moved outside falling edge");
  AST_FLAG_RISE: assert property (
    $rose(flg) |-> ##[0:3] !pre) else $error("flag rose off byte boundary");
  AST_PRESET_LEN: assert property (disable iff (!rstn_in || !test_in)
    $fell(pre) |-> ##[12:20] $rose(pre)) else $error("preset length wrong");
  cover property ($rose(flg));
  cover property ($fell(flg));
  cover property ($rose(oe));
endmodule
bind psc_top psc_props psc_props_i (.*);
`default_nettype wire

// ===== test/psc_host.sv
// Host model that hands bytes to the converter.
`default_nettype none
module psc_host (
  input  wire logic         clk_in,
  output var psc_pkg::psc_byte_t par_out,
  output logic              stb_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    par_out = 8'h00;
    stb_n_out = 1'b1;
  end
  // one strobe per byte; data held around the edge, then scrambled.
  task automatic load(input psc_pkg::psc_byte_t b);
    @(negedge clk_in);
    par_out = b;
    repeat (2) @(negedge clk_in);
    stb_n_out = 1'b0;
    repeat (6) @(negedge clk_in);
    stb_n_out = 1'b1;
    repeat (5) @(negedge clk_in);
    par_out = ~b;
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the parallel to serial converter.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, wclk, en_n, tst, sd, flg, rdy, pre, stb;
  logic [3:0] oe;
  psc_pkg::psc_byte_t par, got;
  psc_pkg::psc_byte_t tbl [9] = '{8'h80, 8'h01, 8'ha5, 8'h5a, 8'hff,
                                  8'h00, 8'h7e, 8'h81, 8'hc3};
  int bad_count, comparisons;
  psc_top psc_top_i (.core_clk_in(clk), .rstn_in(rstn), .parallel_in(par),
    .byte_load_strobe_n_in(stb), .write_clk_in(wclk),
    .output_enable_n_in(en_n), .test_in(tst), .serial_data_out(sd),
    .serial_data_oe_n_out(oe[0]), .byte_done_flag_out(flg),
    .byte_done_flag_oe_n_out(oe[1]), .shift_clock_copy_inv_out(),
    .shift_clock_copy_inv_oe_n_out(oe[2]), .shift_clock_copy_dly_out(),
    .shift_clock_copy_dly_oe_n_out(oe[3]),
    .counter_preset_flag_n_out(pre), .load_ready_out(rdy));
  psc_host psc_host_i (.clk_in(clk), .par_out(par), .stb_n_out(stb));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    wclk = 1'b0;
    #3;
    forever #80 wclk = ~wclk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wait_pre(input logic v);
    for (int i = 0; i < 400 && pre !== v; i++) @(posedge clk);
  endtask
  // bits follow a boundary, MSB first.
  task automatic get_byte(output psc_pkg::psc_byte_t b);
    wait_pre(1'b1);
    wait_pre(1'b0);
    for (int i = 7; i >= 0; i--) begin
      @(posedge wclk);
      b[i] = sd;
    end
  endtask
  task automatic t_fill;
    int k;
    wait_pre(1'b0);
    wait_pre(1'b1);
    @(negedge clk);
    tst = 1'b0;
    k = 0;
    while (rdy === 1'b1 && k < 9) begin
      psc_host_i.load(tbl[k]);
      k++;
    end
    chk({7'h0, rdy}, 8'h00);
    psc_host_i.load(8'hee);
    tst = 1'b1;
    for (int i = 0; i < k; i++) begin
      get_byte(got);
      chk(got, tbl[i]);
    end
    get_byte(got);
    chk(got, tbl[k-1]);
    $display("fill test done");
  endtask
  task automatic t_enable;
    @(negedge clk);
    en_n = 1'b1;
    repeat (6) @(negedge clk);
    chk({4'h0, oe}, 8'h0f);
    en_n = 1'b0;
    repeat (6) @(negedge clk);
    chk({4'h0, oe}, 8'h00);
    $display("enable test done");
  endtask
  task automatic t_test;
    wait_pre(1'b0);
    psc_host_i.load(8'h3c);
    wait_pre(1'b1);
    @(negedge clk);
    tst = 1'b0;
    repeat (640) @(negedge clk);
    chk({7'h0, flg}, 8'h00);
    tst = 1'b1;
    get_byte(got);
    chk(got, 8'h3c);
    $display("test pin test done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    en_n = 1'b0;
    tst = 1'b1;
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    t_fill;
    t_enable;
    t_test;
    test_done;
  end
  // Whole run needs about 23 us; the limit leaves a wide margin.
  initial begin
    #100us;
    bad_count++;
    test_done;
  end
endmodule
`default_nettype wire
